// ### pkg/spio_params.svh
`ifndef SPIO_PARAMS_SVH
`define SPIO_PARAMS_SVH
// ******************************************************************
// Register byte offsets on the AHB-Lite bus.
// ******************************************************************
`define SPIO_OFF_DIR 12'h000
`define SPIO_OFF_PIN 12'h004
`define SPIO_OFF_LAT 12'h008
`define SPIO_OFF_PERIEN 12'h00C
`define SPIO_OFF_SEL_16_17 12'h010
`define SPIO_OFF_SEL_18_19 12'h014
// ******************************************************************
// Field positions and reset values.
// ******************************************************************
`define SPIO_SEL_LO_MSB 4
`define SPIO_SEL_HI_LSB 8
`define SPIO_SEL_HI_MSB 12
`define SPIO_SEL_MASK 16'h1F1F
`define SPIO_DIR_RESET 16'hFFFF
`define SPIO_ZERO16 16'h0000
`define SPIO_SEL_NONE 5'h00
`endif

// ### pkg/spio_pkg.sv
// ******************************************************************
// Types shared by the port files.
// ******************************************************************
package spio_pkg;
  // Address phase captured from the bus.
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic valid;
  } spio_req_t;
  // Drive of one pin: data and enable.
  typedef struct packed {
    logic data;
    logic oe;
  } spio_drive_t;
endpackage : spio_pkg

// ### src/spio_sync.sv
// ******************************************************************
// Two-stage synchroniser for pin levels.
// ******************************************************************
module spio_sync #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // The first stage is read only by the second stage.
  logic [W-1:0] meta_reg;
  // Two flops settle any metastability from the asynchronous pad.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : spio_sync

// ### src/spio_pin_mux.sv
// ******************************************************************
// Per-pin output multiplexer pair and input loop-through block.
// ******************************************************************
module spio_pin_mux
  import spio_pkg::*;
(
  input wire logic implemented,
  input wire logic per_en,
  input spio_drive_t per_drv,
  input spio_drive_t port_drv,
  input wire logic pin_in,
  output spio_drive_t pin_drv,
  output logic per_in
);
  // The peripheral owns the pin only while enabled and driving.
  logic per_owns;
  assign per_owns = per_en && per_drv.oe;
  // Peripheral has priority over the port on both data and enable.
  always_comb begin
    if (!implemented) begin
      pin_drv = '0; // Missing bits never drive.
    end else if (per_owns) begin
      pin_drv = per_drv;
    end else begin
      pin_drv = port_drv;
    end
  end
  // The peripheral only sees the pin when the port is not the driver.
  assign per_in = (implemented && !(port_drv.oe && !per_owns)) ? pin_in : 1'b0;
endmodule : spio_pin_mux

// ### src/spio_port.sv
// Added by the designer: the register offsets and register access over AHB-Lite.
`include "spio_params.svh"
// Operation
// - Peripheral has priority over port on pin
// - Output mux pair selects data and enable
// - Port output never loops into peripheral
// - Driving peripheral disables port driver, pin readable
// - Idle enabled peripheral lets port drive
// - Direction one is input, zero output
// - All pins inputs after reset
// - Latch register reads latch, writes latch
// - Pin register reads pins, writes latch
// - Unimplemented bits read zero and disabled
// - Input-only shared pins are port-driven only
// - Five-bit remap selects at 12-8, 4-0
// - Select bits 15-13, 7-5 read zero
// - Pins 16-19 selects only on large variant
module spio_port
  import spio_pkg::*;
#(
  parameter int W = 16,
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter bit LARGE_VARIANT = 1'b1,
  parameter logic [3:0] REMAP_PIN0 = 4'h0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [W-1:0] per_en,
  input wire logic [W-1:0] per_out,
  input wire logic [W-1:0] per_oe,
  input wire logic [31:0] remap_fn_out,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] per_in
);
  // ******************************************************************
  // Registers.
  // ******************************************************************
  logic [15:0] pin_direction_reg; // One bit per pin, one means input.
  logic [15:0] output_latch_reg; // Port output latch.
  logic [15:0] perien_reg; // Software-set peripheral enables, ORed with per_en.
  logic [15:0] remap_out_select_pins_16_17_reg; // Remap selects, pins 16 and 17.
  logic [15:0] remap_out_select_pins_18_19_reg; // Remap selects, pins 18 and 19.
  logic [W-1:0] pin_sync; // Synchronised pin levels.
  spio_req_t req_reg; // Captured address phase.
  logic [15:0] impl; // Implemented-bit mask at register width.
  assign impl = IMPL_MASK;
  // Every per-pin register path masks with this one copy, so a variant with missing bits
  // differs only in this parameter and never in the register logic.
  // ******************************************************************
  // Bus slave: every transfer completes with zero wait states.
  // ******************************************************************
  logic wr_dir, wr_lat, wr_pin, wr_en, wr_r8, wr_r9;
  logic [15:0] wd; // Write data; the upper half of the bus word is ignored.
  assign wd = hwdata[15:0];
  // Write strobes fire in the data phase, one cycle after the address was taken.
  // The target register then updates at the edge that closes the data phase, so a
  // read issued right after it already sees the new value.
  assign wr_dir = req_reg.valid && req_reg.write && req_reg.addr == `SPIO_OFF_DIR;
  assign wr_pin = req_reg.valid && req_reg.write && req_reg.addr == `SPIO_OFF_PIN;
  assign wr_lat = req_reg.valid && req_reg.write && req_reg.addr == `SPIO_OFF_LAT;
  assign wr_en = req_reg.valid && req_reg.write && req_reg.addr == `SPIO_OFF_PERIEN;
  assign wr_r8 = req_reg.valid && req_reg.write && req_reg.addr == `SPIO_OFF_SEL_16_17;
  assign wr_r9 = req_reg.valid && req_reg.write && req_reg.addr == `SPIO_OFF_SEL_18_19;
  // Reads are served from the address phase: the data is registered at the edge
  // that takes the address and stands through the whole data phase.
  logic rd_req;
  logic [11:0] rd_addr;
  assign rd_req = hready && hsel && htrans[1] && !hwrite;
  assign rd_addr = {haddr[11:2], 2'b00};
  // Capture the address phase of a valid transfer.
  // The size is not decoded: every register is one aligned word.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_reg <= '0;
    end else if (hready) begin
      req_reg.valid <= hsel && htrans[1];
      req_reg.write <= hwrite;
      req_reg.addr <= {haddr[11:2], 2'b00};
    end
  end
  // The slave never stalls and always answers OKAY.
  // Zero wait states suit every register here, since none needs a second cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // ******************************************************************
  // Direction register: all inputs after reset.
  // ******************************************************************
  // Missing bits are stored as ones so they can never turn into outputs.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_direction_reg <= `SPIO_DIR_RESET;
    end else if (wr_dir) begin
      pin_direction_reg <= wd | ~impl; // Missing bits stay disabled inputs.
    end
  end
  // ******************************************************************
  // Output latch: written through either the latch or the pin address.
  // ******************************************************************
  // Only reads tell the two addresses apart: one shows the latch, one the pins.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      output_latch_reg <= `SPIO_ZERO16;
    end else if (wr_lat || wr_pin) begin
      output_latch_reg <= wd & impl;
    end
  end
  // Software enable register for peripherals.
  // An enable only matters together with per_oe: an enabled but silent
  // peripheral still leaves the pin to the port.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      perien_reg <= `SPIO_ZERO16;
    end else if (wr_en) begin
      perien_reg <= wd & impl;
    end
  end
  // ******************************************************************
  // Remap output selects; absent on the small variant.
  // ******************************************************************
  // On the small variant writes are dropped, so the fields keep reading zero.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      remap_out_select_pins_16_17_reg <= `SPIO_ZERO16;
      remap_out_select_pins_18_19_reg <= `SPIO_ZERO16;
    end else if (LARGE_VARIANT) begin
      if (wr_r8) begin
        remap_out_select_pins_16_17_reg <= wd & `SPIO_SEL_MASK;
      end
      if (wr_r9) begin
        remap_out_select_pins_18_19_reg <= wd & `SPIO_SEL_MASK;
      end
    end
  end
  // The four select fields.
  // The low field of each register serves the even pin, the high field the odd pin.
  logic [4:0] sel [4];
  assign sel[0] = remap_out_select_pins_16_17_reg[`SPIO_SEL_LO_MSB:0];
  assign sel[1] = remap_out_select_pins_16_17_reg[`SPIO_SEL_HI_MSB:`SPIO_SEL_HI_LSB];
  assign sel[2] = remap_out_select_pins_18_19_reg[`SPIO_SEL_LO_MSB:0];
  assign sel[3] = remap_out_select_pins_18_19_reg[`SPIO_SEL_HI_MSB:`SPIO_SEL_HI_LSB];
  // ******************************************************************
  // Pin synchroniser and per-pin muxes.
  // ******************************************************************
  // The pads are asynchronous; only the second synchroniser stage is ever read.
  spio_sync #(.W(W)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(pin_i),
    .q(pin_sync)
  );
  logic [W-1:0] mux_o, mux_oe, mux_in;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      spio_drive_t per_d, port_d, pin_d;
      logic remapped, en_eff;
      int ri;
      // Offset of this pin in the remap window; out of range means not remappable.
      assign ri = g - int'(REMAP_PIN0);
      // A remap pin with a nonzero select takes the chosen function.
      assign remapped = LARGE_VARIANT && ri >= 0 && ri < 4 &&
                        sel[ri[1:0]] != `SPIO_SEL_NONE;
      // Input-only peripherals never raise per_oe, so the port stays sole source.
      assign en_eff = per_en[g] || perien_reg[g] || remapped;
      assign per_d.data = remapped ? remap_fn_out[sel[ri[1:0]]] : per_out[g];
      assign per_d.oe = remapped ? 1'b1 : per_oe[g];
      // Direction zero drives the latch out.
      assign port_d.data = output_latch_reg[g];
      assign port_d.oe = !pin_direction_reg[g];
      // A missing bit is forced quiet inside the mux whatever the enables say.
      spio_pin_mux u_mux (
        .implemented(impl[g]),
        .per_en(en_eff),
        .per_drv(per_d),
        .port_drv(port_d),
        .pin_in(pin_sync[g]),
        .pin_drv(pin_d),
        .per_in(mux_in[g])
      );
      assign mux_o[g] = pin_d.data;
      assign mux_oe[g] = pin_d.oe;
    end
  endgenerate
  // Outputs are registered, one cycle after their cause.
  // This costs one cycle of latency but keeps the pads free of decode glitches.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_o <= '0;
      pin_oe <= '0;
      per_in <= '0;
    end else begin
      pin_o <= mux_o;
      pin_oe <= mux_oe;
      per_in <= mux_in;
    end
  end
  // ******************************************************************
  // Read data: registered in the address phase cycle's following edge.
  // ******************************************************************
  logic [15:0] rd_next;
  logic [15:0] pin_rd;
  // The pin path shows the synchronised levels, two edges behind the pads.
  assign pin_rd = 16'(pin_sync) & impl;
  always_comb begin
    unique case (rd_addr)
      `SPIO_OFF_DIR: rd_next = pin_direction_reg & impl;
      `SPIO_OFF_PIN: rd_next = pin_rd; // Pins stay readable while a peripheral drives.
      `SPIO_OFF_LAT: rd_next = output_latch_reg;
      `SPIO_OFF_PERIEN: rd_next = perien_reg;
      `SPIO_OFF_SEL_16_17: rd_next = remap_out_select_pins_16_17_reg;
      `SPIO_OFF_SEL_18_19: rd_next = remap_out_select_pins_18_19_reg;
      default: rd_next = `SPIO_ZERO16;
    endcase
  end
  // Unmapped addresses read as zero.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= '0;
    end else if (rd_req) begin
      hrdata <= {16'h0000, rd_next};
    end
  end
  // ******************************************************************
  // Checks.
  // ******************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Register writes: each strobe leaves exactly the masked data behind.
  dir_write_a: assert property (wr_dir |=> pin_direction_reg == ($past(wd) | ~impl))
    else $error("direction write lost");
  pin_write_a: assert property (wr_pin |=> output_latch_reg == ($past(wd) & impl))
    else $error("pin write did not reach latch");
  lat_write_a: assert property (wr_lat |=> output_latch_reg == ($past(wd) & impl))
    else $error("latch write lost");
  // Reserved select bits can never hold a one.
  sel_zero_a: assert property (
    (remap_out_select_pins_16_17_reg & ~`SPIO_SEL_MASK) == `SPIO_ZERO16)
    else $error("reserved select bits set");
  sel9_zero_a: assert property (
    (remap_out_select_pins_18_19_reg & ~`SPIO_SEL_MASK) == `SPIO_ZERO16)
    else $error("reserved select bits set");
  // The small variant has no selects for pins 18 and 19 at all.
  no_sel_a: assert property (wr_r9 |=> remap_out_select_pins_18_19_reg ==
    (LARGE_VARIANT ? ($past(wd) & `SPIO_SEL_MASK) : `SPIO_ZERO16))
    else $error("select present on small variant");
  // After reset every pin is an input and nothing drives.
  dir_reset_a: assert property (!$past(rstn) |->
    pin_direction_reg == `SPIO_DIR_RESET && pin_oe == '0)
    else $error("pins not inputs after reset");
  // Pin ownership: a driving peripheral first, then the port, then nobody.
  prio_a: assert property (((per_en[0] || perien_reg[0]) && per_oe[0] && impl[0] &&
    !g_pin[0].remapped) |=> pin_oe[0] && pin_o[0] == $past(per_out[0]))
    else $error("peripheral lost priority");
  port_drive_a: assert property (((per_en[1] || perien_reg[1]) && !per_oe[1] &&
    !g_pin[1].remapped && impl[1] && !pin_direction_reg[1]) |=>
    pin_oe[1] && pin_o[1] == $past(output_latch_reg[1]))
    else $error("port failed to drive");
  dir_in_a: assert property ((impl[4] && !per_oe[4] && !g_pin[4].remapped)
    |=> pin_oe[4] == !$past(pin_direction_reg[4]))
    else $error("direction bit did not set the driver");
  remap_route_a: assert property ((LARGE_VARIANT && impl[REMAP_PIN0] &&
    sel[0] != `SPIO_SEL_NONE) |=> pin_oe[REMAP_PIN0] &&
    pin_o[REMAP_PIN0] == $past(remap_fn_out[sel[0]]))
    else $error("remapped function not routed");
  // Loop-through: a port-driven pin reads zero on the peripheral side.
  loop_a: assert property ((!pin_direction_reg[2] && !per_oe[2] &&
    !g_pin[2].remapped) |=> per_in[2] == 1'b0)
    else $error("port output looped into peripheral");
  unimpl_a: assert property (!impl[3] |=> !pin_oe[3])
    else $error("unimplemented bit drives");
  // Register reads: the latch and the pins come from different sources.
  lat_read_a: assert property ((rd_req && rd_addr == `SPIO_OFF_LAT) |=>
    hrdata == {16'h0000, $past(output_latch_reg)})
    else $error("latch read returned another value");
  pin_read_a: assert property ((rd_req && rd_addr == `SPIO_OFF_PIN) |=>
    hrdata == {16'h0000, $past(16'(pin_sync)) & impl})
    else $error("pin read returned another value");
  // Register access relies on a bus that never stalls and never errors.
  rdy_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  // Scenarios that the random bench should reach.
  cov_wr_c: cover property (wr_pin ##1 wr_lat);
  cov_per_c: cover property ((per_en[0] || perien_reg[0]) && per_oe[0]);
  cov_remap_c: cover property (sel[0] != 0);
  cov_loop_c: cover property (!pin_direction_reg[2] && !per_oe[2] && pin_oe[2]);
endmodule : spio_port

// ### tb/spio_pads.sv
// ******************************************************************
// Board wiring outside the shared port pins.
// ******************************************************************
module spio_pads (
  input wire logic ref_clk,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_oe,
  output logic [15:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pad that nobody drives wanders, so this flips every cycle.
  // That way a stale level can never pass for a real one.
  logic [15:0] float_reg = 16'h5555;
  // Advance the wander pattern on every clock.
  always_ff @(posedge ref_clk) begin
    float_reg <= ~float_reg;
  end
  // The device driver wins; the board drives only where the device lets go.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pad[i] = pin_oe[i] ? pin_o[i] : (ext_oe[i] ? ext_val[i] : float_reg[i]);
    end
  end
endmodule : spio_pads

// ### tb/tb_top.sv
`include "spio_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
// ******************************************************************
// Self-checking bench for the shared port.
// ******************************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Bits 3 and 15 are missing on this variant.
  localparam logic [15:0] IMPL = 16'h7FF7;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] rfo = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [15:0] per_en = 16'h0;
  logic [15:0] per_out = 16'h0;
  logic [15:0] per_oe = 16'h0;
  logic [15:0] ext_val = 16'h0;
  logic [15:0] ext_oe = 16'h0;
  logic [15:0] pin_o;
  logic [15:0] pin_oe;
  logic [15:0] per_in;
  logic [15:0] pad;
  int mismatches = 0;
  int check_count = 0;
  int seed = 46404;
  // Reference copies of the registers, kept as plain integers.
  int m_dir;
  int m_lat;
  int m_s8;
  int m_s9;
  int m_en;
  spio_port #(.W(16), .IMPL_MASK(IMPL), .LARGE_VARIANT(1'b1), .REMAP_PIN0(4'h0)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .per_en(per_en),
    .per_out(per_out), .per_oe(per_oe), .remap_fn_out(rfo), .pin_i(pad),
    .pin_o(pin_o), .pin_oe(pin_oe), .per_in(per_in));
  spio_pads u_pads (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_oe(ext_oe), .pad(pad));
  // Free-running 200 MHz clock.
  initial begin
    forever begin
      #2.5;
      ref_clk = ~ref_clk;
    end
  end
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // Waits for ready at a rising edge; a stuck slave ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        report_and_stop();
      end
      @(posedge ref_clk);
    end
  endtask : wait_ready
  // One single word transfer; read data is taken at the closing edge.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] wd);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask : bus
  // Reads a register and compares the whole word, upper half zero.
  task automatic rdck(input logic [11:0] a, input int e);
    bus(1'b0, a, 16'h0);
    `CHK(rd, {16'h0, 16'(e)})
  endtask : rdck
  // Reset pulse; the model returns to its reset contents, then m_en is set to all ones and written.
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    m_dir = `SPIO_DIR_RESET;
    m_lat = 0;
    m_s8 = 0;
    m_s9 = 0;
    m_en = 'hFFFF;
    bus(1'b1, `SPIO_OFF_PERIEN, 16'(m_en));
  endtask : do_reset
  // Predicts every pad from the model, lets the pins settle, then compares.
  task automatic settle_and_check();
    logic [15:0] eoe;
    logic [15:0] eo;
    logic [15:0] pdrv;
    logic [15:0] epad;
    int sel[4];
    int s;
    sel = '{m_s8 & 31, (m_s8 >> 8) & 31, m_s9 & 31, (m_s9 >> 8) & 31};
    for (int i = 0; i < 16; i++) begin
      s = (i < 4) ? sel[i] : 0;
      pdrv[i] = 1'b0;
      if (!IMPL[i]) begin
        eoe[i] = 1'b0;
        eo[i] = 1'b0;
      end else if (s != 0) begin
        eoe[i] = 1'b1;
        eo[i] = rfo[s];
      end else if ((per_en[i] || m_en[i]) && per_oe[i]) begin
        eoe[i] = 1'b1;
        eo[i] = per_out[i];
      end else begin
        eoe[i] = !m_dir[i];
        eo[i] = m_lat[i];
        pdrv[i] = eoe[i];
      end
    end
    epad = (eoe & eo) | (~eoe & ext_val);
    ext_oe <= ~eoe & IMPL;
    repeat (6) @(posedge ref_clk);
    `CHK(pin_oe, eoe)
    `CHK(pin_o & eoe, eo & eoe)
    `CHK(per_in & IMPL, epad & ~pdrv & IMPL)
    rdck(`SPIO_OFF_DIR, m_dir & IMPL);
    rdck(`SPIO_OFF_LAT, m_lat & IMPL);
    rdck(`SPIO_OFF_PIN, epad & IMPL);
    rdck(`SPIO_OFF_SEL_16_17, m_s8 & `SPIO_SEL_MASK);
    rdck(`SPIO_OFF_SEL_18_19, m_s9 & `SPIO_SEL_MASK);
    rdck(12'h020, 0);
  endtask : settle_and_check
  // Random configurations; a second reset lands in mid-run.
  initial begin
    do_reset();
    settle_and_check();
    for (int it = 0; it < 40; it++) begin
      // Remapped bits 3:0 get no per_en; only m_en can put them on the plain peripheral path.
      per_en <= 16'($random(seed)) & 16'hFFF0;
      per_out <= 16'($random(seed));
      per_oe <= 16'($random(seed));
      ext_val <= 16'($random(seed));
      rfo <= $random(seed);
      m_dir = $random(seed) & 'hFFFF;
      m_lat = $random(seed) & 'hFFFF;
      m_s8 = it[1] ? 0 : $random(seed) & 'hFFFF;
      m_s9 = it[2] ? 0 : $random(seed) & 'hFFFF;
      m_en = $random(seed) & 'hFFFF;
      bus(1'b1, `SPIO_OFF_PERIEN, 16'(m_en));
      bus(1'b1, `SPIO_OFF_DIR, 16'(m_dir));
      bus(1'b1, it[0] ? `SPIO_OFF_PIN : `SPIO_OFF_LAT, 16'(m_lat));
      bus(1'b1, `SPIO_OFF_SEL_16_17, 16'(m_s8));
      bus(1'b1, `SPIO_OFF_SEL_18_19, 16'(m_s9));
      bus(1'b1, 12'h020, 16'hFFFF);
      settle_and_check();
      if (it == 20) begin
        do_reset();
        settle_and_check();
      end
    end
    report_and_stop();
  end
endmodule : tb_top
